/* File: core/adcsp_port.sv */
// serial command port of the measurement converter, sampled on the system clock
// Notes on behaviour
// - every transaction opens with a command byte; no other access before it
// - after reset the next byte shifted in is a command byte
// - command byte picks read or write and the target register
// - write data only from serial input, read data only on serial output
// - all shifting is timed by the host serial clock
// - result ready goes low when a new word reaches the output register
// - result ready returns high once a data register read completes
// - result ready goes high before the output register is updated
// - active low select gates the port for shared serial lines
// - with select tied low, clock, input and output lines suffice
// - command register MSB reads back the result ready state
// - polarity strap low inverts the serial clock, swapping edge roles
// - the same conversion word may be read again after the first read
// - reset input returns the port to its initial state
// - 32 consecutive ones on serial input reset the port
// - after the ones reset the next transfer is a command byte
// - the ones reset leaves all register contents unchanged
// - half duplex: output idle during writes, input only watched for 32 ones during reads
// - selected access follows the eighth command clock with no gap
// - words travel most significant bit first in both directions
module adcsp_port
  import adcsp_pkg::*;
#(
  parameter int                                   DATA_W     = adcsp_pkg::ADCSP_DATA_W,
  parameter int                                   FIFO_DEPTH = adcsp_pkg::ADCSP_FIFO_DEPTH,
  parameter int                                   UPD_HOLD   = adcsp_pkg::ADCSP_UPD_HOLD,
  parameter logic [ADCSP_NREG*ADCSP_LEN_W-1:0]    REG_LEN    = adcsp_pkg::ADCSP_REG_LEN_DEF
) (
  // clock and reset
  input  wire logic                                       i_sys_clk,
  input  wire logic                                       i_rstn,
  // serial pins
  input  wire logic                                       i_sclk,
  input  wire logic                                       i_din,
  input  wire logic                                       i_cs_n,
  input  wire logic                                       i_clock_polarity_strap,
  output logic                                            o_dout,
  output logic                                            o_dout_oe_n,
  output logic                                            o_result_ready_n,
  // conversion words from the filter
  input  wire logic                                       i_conv_valid,
  input  wire logic [DATA_W-1:0]                          i_conv_data,
  output logic                                            o_conv_ready,
  // register file outside the port
  input  wire logic [adcsp_pkg::ADCSP_NREG*DATA_W-1:0]    i_reg_rdata,
  output logic                                            o_reg_wr_stb,
  output logic [adcsp_pkg::ADCSP_ADDR_W-1:0]              o_reg_wr_addr,
  output logic [DATA_W-1:0]                               o_reg_wr_data,
  // status
  output logic [adcsp_pkg::ADCSP_CMD_W-1:0]               o_cmd
);
  import adcsp_pkg::*;

  typedef struct packed {
    logic                    sclk_s1;
    logic                    sclk_s2;
    logic                    sclk_d;
    logic                    din_s1;
    logic                    din_s2;
    logic                    csn_s1;
    logic                    csn_s2;
    logic                    pol_s1;
    logic                    pol_s2;
    adcsp_phase_t            phase;
    logic [ADCSP_CMD_W-1:0]  cmd;
    logic [ADCSP_ADDR_W-1:0] sel;
    logic [ADCSP_LEN_W-1:0]  len;
    logic [ADCSP_LEN_W-1:0]  bits;
    logic [DATA_W-1:0]       sh;
    logic [ADCSP_ONES_W-1:0] ones;
    logic                    dout;
    logic                    oe_n;
    logic                    wr_stb;
    logic [ADCSP_ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0]       wr_data;
    adcsp_upd_t              upd;
    logic [ADCSP_UPD_W-1:0]  upd_cnt;
    logic [DATA_W-1:0]       outreg;
    logic                    have_word;
    logic                    word_read;
    logic                    rdy_n;
    logic                    pop;
  } adcsp_st_t;

  adcsp_st_t         q_r;
  adcsp_st_t         q_nxt;
  logic              fifo_valid;
  logic [DATA_W-1:0] fifo_data;
  logic              fifo_in_ready;
  logic              sck_now;
  logic              sck_prev;
  logic              active;
  logic              sample_edge;
  logic              launch_edge;
  logic              data_rd_busy;

  function automatic logic [ADCSP_LEN_W-1:0] reg_len(input logic [ADCSP_ADDR_W-1:0] idx);
    reg_len = REG_LEN[idx*ADCSP_LEN_W +: ADCSP_LEN_W];
  endfunction

  // put the low len bits at the top of the shifter so they leave msb first
  function automatic logic [DATA_W-1:0] left_align(input logic [DATA_W-1:0] v,
                                                    input logic [ADCSP_LEN_W-1:0] len);
    left_align = v << (DATA_W - int'(len));
  endfunction

  adcsp_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_sys_clk),
    .i_rstn      (i_rstn),
    .i_in_valid  (i_conv_valid),
    .i_in_data   (i_conv_data),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (fifo_valid),
    .o_out_data  (fifo_data),
    .i_out_ready (q_r.pop)
  );

  // normalise the clock so the sample edge is always a rising one
  assign sck_now      = q_r.pol_s2 ? q_r.sclk_s2 : ~q_r.sclk_s2;
  // previous level is stored normalised, idle reads 1 for either strap, so reset cannot fake an edge
  assign sck_prev     = q_r.sclk_d;
  assign active       = !q_r.csn_s2;
  assign sample_edge  = active && sck_now && !sck_prev;
  assign launch_edge  = active && !sck_now && sck_prev;
  assign data_rd_busy = (q_r.phase == ADCSP_PH_RD) && (q_r.sel == ADCSP_DATA_IDX);

  always_comb begin
    logic [ADCSP_CMD_W-1:0]  cbyte;
    logic [ADCSP_ADDR_W-1:0] csel;
    logic [DATA_W-1:0]       rword;
    logic [DATA_W-1:0]       shin;
    cbyte = '0;
    csel  = '0;
    rword = '0;
    shin  = '0;
    q_nxt = q_r;

    // only the second stage of each synchroniser is read by logic
    q_nxt.sclk_s1 = i_sclk;
    q_nxt.sclk_s2 = q_r.sclk_s1;
    q_nxt.sclk_d  = sck_now;
    q_nxt.din_s1  = i_din;
    q_nxt.din_s2  = q_r.din_s1;
    q_nxt.csn_s1  = i_cs_n;
    q_nxt.csn_s2  = q_r.csn_s1;
    q_nxt.pol_s1  = i_clock_polarity_strap;
    q_nxt.pol_s2  = q_r.pol_s1;
    q_nxt.wr_stb  = 1'b0;
    q_nxt.pop     = 1'b0;

    shin = {q_r.sh[DATA_W-2:0], q_r.din_s2};

    if (sample_edge) begin
      q_nxt.ones = q_r.din_s2 ? q_r.ones + 1'b1 : '0;
      if (q_r.din_s2 && (q_r.ones == ADCSP_ONES_W'(ADCSP_ONES_RESET - 1))) begin
        // registers and output word are left as they are
        q_nxt.phase = ADCSP_PH_CMD;
        q_nxt.bits  = '0;
        q_nxt.sh    = '0;
        q_nxt.ones  = '0;
      end else begin
        unique case (q_r.phase)
          ADCSP_PH_CMD: begin
            q_nxt.sh   = shin;
            q_nxt.bits = q_r.bits + 1'b1;
            if (q_r.bits == ADCSP_LEN_W'(ADCSP_CMD_W - 1)) begin
              cbyte       = shin[ADCSP_CMD_W-1:0];
              csel        = cbyte[ADCSP_CMD_RS_LSB +: ADCSP_ADDR_W];
              q_nxt.cmd   = cbyte;
              q_nxt.sel   = csel;
              q_nxt.len   = reg_len(csel);
              q_nxt.bits  = '0;
              q_nxt.sh    = '0;
              // access set up on the same edge, no gap needed
              if (cbyte[ADCSP_CMD_RW_BIT]) begin
                if (csel == ADCSP_COMM_IDX) begin
                  rword = DATA_W'({q_r.rdy_n, cbyte[ADCSP_CMD_W-2:0]});
                end else if (csel == ADCSP_DATA_IDX) begin
                  rword = q_r.outreg;
                end else begin
                  rword = i_reg_rdata[csel*DATA_W +: DATA_W];
                end
                q_nxt.sh    = left_align(rword, q_nxt.len);
                q_nxt.phase = ADCSP_PH_RD;
              end else if (csel != ADCSP_COMM_IDX) begin
                q_nxt.phase = ADCSP_PH_WR;
              end
            end
          end
          ADCSP_PH_WR: begin
            q_nxt.sh   = shin;
            q_nxt.bits = q_r.bits + 1'b1;
            if (q_r.bits == q_r.len - 1'b1) begin
              // the output data register is read only
              q_nxt.wr_stb  = (q_r.sel != ADCSP_DATA_IDX);
              q_nxt.wr_addr = q_r.sel;
              q_nxt.wr_data = shin;
              q_nxt.phase   = ADCSP_PH_CMD;
              q_nxt.bits    = '0;
              q_nxt.sh      = '0;
            end
          end
          ADCSP_PH_RD: begin
            // serial input is not shifted in during a read
            q_nxt.bits = q_r.bits + 1'b1;
            if (q_r.bits == q_r.len - 1'b1) begin
              q_nxt.phase = ADCSP_PH_CMD;
              q_nxt.bits  = '0;
              q_nxt.sh    = '0;
              if (q_r.sel == ADCSP_DATA_IDX) begin
                q_nxt.rdy_n     = 1'b1;
                q_nxt.word_read = 1'b1;
              end
            end
          end
        endcase
      end
    end else if (launch_edge && (q_r.phase == ADCSP_PH_RD)) begin
      q_nxt.dout = q_r.sh[DATA_W-1];
      q_nxt.sh   = {q_r.sh[DATA_W-2:0], 1'b0};
    end

    // drive the output only while selected and reading
    q_nxt.oe_n = !(active && (q_nxt.phase == ADCSP_PH_RD));

    // output register update; a word still unread stalls the fifo so it fills
    unique case (q_r.upd)
      ADCSP_UP_IDLE: begin
        if (fifo_valid && (!q_r.have_word || q_r.word_read) && !data_rd_busy) begin
          q_nxt.rdy_n   = 1'b1;
          q_nxt.upd     = ADCSP_UP_HOLD;
          q_nxt.upd_cnt = ADCSP_UPD_W'(UPD_HOLD - 1);
        end
      end
      ADCSP_UP_HOLD: begin
        q_nxt.rdy_n = 1'b1;
        // a data read under way keeps the old word until it ends
        if (!data_rd_busy) begin
          if (q_r.upd_cnt == '0) begin
            q_nxt.outreg    = fifo_data;
            q_nxt.pop       = 1'b1;
            q_nxt.have_word = 1'b1;
            q_nxt.word_read = 1'b0;
            q_nxt.rdy_n     = 1'b0;
            q_nxt.upd       = ADCSP_UP_IDLE;
          end else begin
            q_nxt.upd_cnt = q_r.upd_cnt - 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q_r         <= '0;
      q_r.sclk_s1 <= 1'b1;
      q_r.sclk_s2 <= 1'b1;
      q_r.sclk_d  <= 1'b1;
      q_r.csn_s1  <= 1'b1;
      q_r.csn_s2  <= 1'b1;
      q_r.pol_s1  <= 1'b1;
      q_r.pol_s2  <= 1'b1;
      q_r.phase   <= ADCSP_PH_CMD;
      q_r.cmd     <= ADCSP_CMD_RST;
      q_r.upd     <= ADCSP_UP_IDLE;
      q_r.oe_n    <= 1'b1;
      q_r.rdy_n   <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign o_dout           = q_r.dout;
  assign o_dout_oe_n      = q_r.oe_n;
  assign o_result_ready_n = q_r.rdy_n;
  assign o_conv_ready     = fifo_in_ready;
  assign o_reg_wr_stb     = q_r.wr_stb;
  assign o_reg_wr_addr    = q_r.wr_addr;
  assign o_reg_wr_data    = q_r.wr_data;
  assign o_cmd            = q_r.cmd;

endmodule

/* File: core/adcsp_pkg.sv */
// shared constants and types for the converter serial command port
package adcsp_pkg;

  // register map shape
  localparam int ADCSP_NREG     = 8;
  localparam int ADCSP_ADDR_W   = 3;
  localparam int ADCSP_DATA_W   = 24;
  localparam int ADCSP_LEN_W    = 5;
  localparam int ADCSP_CMD_W    = 8;

  // command byte fields
  localparam int ADCSP_CMD_RDY_BIT = 7;
  localparam int ADCSP_CMD_RS_LSB  = 4;
  localparam int ADCSP_CMD_RW_BIT  = 3;

  // register indices
  localparam logic [2:0] ADCSP_COMM_IDX = 3'h0;
  localparam logic [2:0] ADCSP_DATA_IDX = 3'h5;

  // access length of each register in bits, index 0 in the low slice
  localparam logic [ADCSP_NREG*ADCSP_LEN_W-1:0] ADCSP_REG_LEN_DEF = {
    5'h18, 5'h18, 5'h18, 5'h08, 5'h08, 5'h08, 5'h08, 5'h08
  };

  // values after reset
  localparam logic [ADCSP_CMD_W-1:0] ADCSP_CMD_RST = 8'h00;

  // counts
  localparam int ADCSP_ONES_RESET = 32;
  localparam int ADCSP_ONES_W     = 6;
  localparam int ADCSP_FIFO_DEPTH = 32;
  localparam int ADCSP_UPD_HOLD   = 8;
  localparam int ADCSP_UPD_W      = 8;

  typedef enum logic [1:0] {ADCSP_PH_CMD, ADCSP_PH_WR, ADCSP_PH_RD} adcsp_phase_t;
  typedef enum logic {ADCSP_UP_IDLE, ADCSP_UP_HOLD} adcsp_upd_t;

endpackage

/* File: core/adcsp_fifo.sv */
// conversion word fifo with registered read data
module adcsp_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  // filling side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // draining side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [AW-1:0]    wp;
    logic [AW-1:0]    rp;
    logic [AW:0]      cnt;
    logic             in_ready;
    logic             ov;
    logic [WIDTH-1:0] od;
  } adcsp_fifo_st_t;

  adcsp_fifo_st_t   q_r;
  adcsp_fifo_st_t   q_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             take;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign push = i_in_valid && q_r.in_ready;
  // refill the output stage whenever it is empty or being consumed
  assign take = (q_r.cnt != '0) && (!q_r.ov || i_out_ready);

  always_comb begin
    q_nxt = q_r;
    if (push) begin
      q_nxt.wp = ptr_inc(q_r.wp);
    end
    if (take) begin
      q_nxt.od = mem[q_r.rp];
      q_nxt.ov = 1'b1;
      q_nxt.rp = ptr_inc(q_r.rp);
    end else if (i_out_ready) begin
      q_nxt.ov = 1'b0;
    end
    q_nxt.cnt      = q_r.cnt + (AW+1)'(push) - (AW+1)'(take);
    q_nxt.in_ready = q_nxt.cnt < (AW+1)'(DEPTH);
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q_r          <= '0;
      q_r.in_ready <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[q_r.wp] <= i_in_data;
    end
  end

  assign o_in_ready  = q_r.in_ready;
  assign o_out_valid = q_r.ov;
  assign o_out_data  = q_r.od;

endmodule

/* File: sim/adcsp_port_chk.sv */
// assertion checker for the serial command port, bound to its top module
module adcsp_port_chk
  import adcsp_pkg::*;
#(
  parameter int                                DATA_W   = ADCSP_DATA_W,
  parameter int                                UPD_HOLD = ADCSP_UPD_HOLD,
  parameter logic [ADCSP_NREG*ADCSP_LEN_W-1:0] REG_LEN  = ADCSP_REG_LEN_DEF
) (
  // clock and reset
  input wire logic                    i_sys_clk,
  input wire logic                    i_rstn,
  // watched pins
  input wire logic                    i_cs_n,
  input wire logic                    o_dout_oe_n,
  input wire logic                    o_result_ready_n,
  input wire logic                    o_conv_ready,
  input wire logic                    o_reg_wr_stb,
  input wire logic [ADCSP_ADDR_W-1:0] o_reg_wr_addr,
  input wire logic [DATA_W-1:0]       o_reg_wr_data,
  input wire logic [ADCSP_CMD_W-1:0]  o_cmd
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rstn);
  // saturating count of cycles with result ready held high
  logic [7:0] hi_cnt_r;
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) hi_cnt_r <= 8'h00;
    else if (!o_result_ready_n) hi_cnt_r <= 8'h00;
    else if (hi_cnt_r != 8'hff) hi_cnt_r <= hi_cnt_r + 8'h01;
  end
  chk_stb_pulse: assert property (o_reg_wr_stb |=> !o_reg_wr_stb)
    else $error("write strobe longer than one cycle");
  chk_stb_target: assert property (o_reg_wr_stb |-> !o_cmd[ADCSP_CMD_RW_BIT] && o_reg_wr_addr != ADCSP_DATA_IDX
    && o_reg_wr_addr != ADCSP_COMM_IDX && o_reg_wr_addr == o_cmd[ADCSP_CMD_RS_LSB +: ADCSP_ADDR_W])
    else $error("write strobe does not match the command");
  chk_wr_len: assert property (o_reg_wr_stb |-> (o_reg_wr_data >> REG_LEN[o_reg_wr_addr*ADCSP_LEN_W +: ADCSP_LEN_W]) == '0)
    else $error("write data wider than register length");
  chk_oe_read: assert property (!o_dout_oe_n |-> o_cmd[ADCSP_CMD_RW_BIT])
    else $error("output driven outside a read");
  chk_oe_desel: assert property (i_cs_n [*6] |-> o_dout_oe_n)
    else $error("output driven while deselected");
  chk_cmd_desel: assert property (i_cs_n [*6] |=> $stable(o_cmd))
    else $error("command changed while deselected");
  chk_rdy_hold: assert property ($fell(o_result_ready_n) |-> hi_cnt_r >= UPD_HOLD)
    else $error("result ready not held high before update");
  chk_rst_vals: assert property ($rose(i_rstn) |-> o_result_ready_n && o_dout_oe_n && !o_reg_wr_stb
    && o_cmd == ADCSP_CMD_RST && o_conv_ready)
    else $error("outputs not at reset values");
  cov_word: cover property ($fell(o_result_ready_n));
  cov_write: cover property (o_reg_wr_stb);
  cov_read: cover property ($fell(o_dout_oe_n));
  cov_full: cover property (!o_conv_ready);
endmodule

bind adcsp_port adcsp_port_chk #(.DATA_W(DATA_W), .UPD_HOLD(UPD_HOLD), .REG_LEN(REG_LEN)) i_chk (
  .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_cs_n(i_cs_n), .o_dout_oe_n(o_dout_oe_n),
  .o_result_ready_n(o_result_ready_n), .o_conv_ready(o_conv_ready), .o_reg_wr_stb(o_reg_wr_stb),
  .o_reg_wr_addr(o_reg_wr_addr), .o_reg_wr_data(o_reg_wr_data), .o_cmd(o_cmd));

/* File: sim/adcsp_host.sv */
// host serial master model: clock, data in and select
module adcsp_host (
  // bench clock and strap
  input  wire logic i_clk,
  input  wire logic i_strap,
  // serial pins
  input  wire logic i_dout,
  output logic      o_sclk,
  output logic      o_din,
  output logic      o_cs_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_sclk = 1'b1;
    o_din  = 1'b0;
    o_cs_n = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // launch on leaving idle, sample on return; half period is 4 system cycles
  task automatic xfer(input int n, input logic [31:0] w, output logic [31:0] r);
    r = '0;
    for (int b = n - 1; b >= 0; b--) begin
      tick(1);
      o_sclk = ~i_strap;
      o_din  = w[b];
      tick(4);
      o_sclk = i_strap;
      tick(1);
      r = {r[30:0], i_dout};
      tick(2);
    end
    // idle data line is not left at the last bit
    o_din = ~o_din;
  endtask
  // clock is parked at the strap's idle level whenever select moves
  task automatic sel(input logic v);
    tick(1);
    o_cs_n = v;
    o_sclk = i_strap;
    tick(4);
  endtask
endmodule

/* File: sim/tb_top.sv */
// self-checking bench for the serial command port
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import adcsp_pkg::*;
  logic                               clk        = 1'b0;
  logic                               rstn       = 1'b0;
  logic                               strap      = 1'b1;
  logic                               conv_valid = 1'b0;
  logic [ADCSP_DATA_W-1:0]            conv_data  = '0;
  logic [ADCSP_NREG*ADCSP_DATA_W-1:0] rdata      = '0;
  logic [31:0]                        rnd        = 32'h98aa;
  logic [ADCSP_DATA_W-1:0]            q[$];
  int                                 num_errors = 0;
  int                                 n_checks   = 0;
  int                                 n_stb      = 0;
  wire                                sclk, din, cs_n, dout, oe_n, rdy_n, conv_rdy, stb;
  wire  [ADCSP_ADDR_W-1:0]            wr_addr;
  wire  [ADCSP_DATA_W-1:0]            wr_data;
  wire  [ADCSP_CMD_W-1:0]             cmd;
  // released output line shows a toggling pattern, never the last bit
  wire                                dout_pin = oe_n ? clk : dout;
  adcsp_port i_dut (
    .i_sys_clk(clk), .i_rstn(rstn), .i_sclk(sclk), .i_din(din), .i_cs_n(cs_n),
    .i_clock_polarity_strap(strap), .o_dout(dout), .o_dout_oe_n(oe_n), .o_result_ready_n(rdy_n),
    .i_conv_valid(conv_valid), .i_conv_data(conv_data), .o_conv_ready(conv_rdy), .i_reg_rdata(rdata),
    .o_reg_wr_stb(stb), .o_reg_wr_addr(wr_addr), .o_reg_wr_data(wr_data), .o_cmd(cmd));
  adcsp_host i_host (.i_clk(clk), .i_strap(strap), .i_dout(dout_pin), .o_sclk(sclk), .o_din(din), .o_cs_n(cs_n));
  always #5 clk = ~clk;
  always @(posedge clk) if (stb === 1'b1) n_stb++;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int reg_len(input int k);
    return int'(ADCSP_REG_LEN_DEF[k*ADCSP_LEN_W +: ADCSP_LEN_W]);
  endfunction
  function automatic logic [31:0] frame(input int k, input logic rd, input logic [31:0] d);
    return ({1'b0, 3'(k), rd, 3'h0, 24'h000000} >> (24 - reg_len(k))) | d;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (num_errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wait_stb(input int k, input logic [31:0] d);
    int i = 0;
    while (stb !== 1'b1 && i < 30) begin
      @(posedge clk);
      #1;
      i++;
    end
    check(stb, 32'h1);
    check(wr_addr, k);
    check(wr_data, d);
  endtask
  task automatic wr(input int k, input logic [31:0] d);
    logic [31:0] r;
    i_host.xfer(8 + reg_len(k), frame(k, 1'b0, d), r);
    wait_stb(k, d);
  endtask
  // input line carries junk during reads, which must be ignored
  task automatic rd(input int k, output logic [31:0] v);
    logic [31:0] r;
    logic [31:0] m;
    m = (32'h1 << reg_len(k)) - 32'h1;
    rnd = lfsr(rnd);
    i_host.xfer(8 + reg_len(k), frame(k, 1'b1, rnd & m), r);
    v = r & m;
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic wait_rdy();
    int i = 0;
    while (rdy_n !== 1'b0 && i < 200) begin
      @(posedge clk);
      #1;
      i++;
    end
  endtask
  task automatic fill(input int n);
    conv_valid = 1'b1;
    for (int i = 0; i < n; i++) begin
      rnd = lfsr(rnd);
      conv_data = rnd[23:0];
      @(negedge clk);
      if (conv_rdy !== 1'b1) break;
      @(posedge clk);
      q.push_back(conv_data);
      #1;
    end
    if (conv_rdy !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    conv_valid = 1'b0;
  endtask
  initial begin
    logic [31:0] v;
    int k;
    int n0;
    repeat (6) @(posedge clk);
    #1;
    check({rdy_n, oe_n, stb, cmd, conv_rdy}, {3'b110, 8'h00, 1'b1});
    repeat (6) @(posedge clk);
    #1;
    rstn = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    wr(1, 32'hff);
    wr(7, 32'h800001);
    for (int n = 0; n < 12; n++) begin
      k = (n % 6) + 1;
      if (k > 4) k++;
      rnd = lfsr(rnd);
      wr(k, rnd & ((32'h1 << reg_len(k)) - 32'h1));
      rnd = lfsr(rnd);
      rdata[k*ADCSP_DATA_W +: ADCSP_DATA_W] = rnd[23:0];
      rd(k, v);
      check(v, rdata[k*ADCSP_DATA_W +: ADCSP_DATA_W] & ((32'h1 << reg_len(k)) - 32'h1));
    end
    fill(1);
    wait_rdy();
    check(rdy_n, 32'h0);
    rd(0, v);
    check(v, 32'h08);
    rd(5, v);
    check(v, q[0]);
    check(rdy_n, 32'h1);
    rd(0, v);
    check(v, 32'h88);
    rd(5, v);
    check(v, q.pop_front());
    n0 = n_stb;
    i_host.xfer(3, 32'h2, v);
    i_host.xfer(32, 32'hffffffff, v);
    wr(2, 32'h5a);
    @(posedge clk);
    #1;
    check(n_stb, n0 + 1);
    i_host.xfer(8, 32'h30, v);
    i_host.sel(1'b1);
    i_host.xfer(8, 32'h96, v);
    i_host.sel(1'b0);
    i_host.xfer(8, 32'h3c, v);
    wait_stb(3, 32'h3c);
    @(posedge clk);
    #1;
    n0 = n_stb;
    i_host.xfer(8, 32'h00, v);
    rnd = lfsr(rnd);
    i_host.xfer(32, {8'h50, rnd[23:0]}, v);
    repeat (10) @(posedge clk);
    check(n_stb, n0);
    i_host.sel(1'b1);
    strap = 1'b0;
    i_host.sel(1'b1);
    i_host.sel(1'b0);
    wr(6, 32'ha5c3e1);
    rdata[4*ADCSP_DATA_W +: ADCSP_DATA_W] = 24'h0000c6;
    rd(4, v);
    check(v, 32'hc6);
    check(cmd, 32'h48);
    rstn = 1'b0;
    #1;
    check({cmd, oe_n}, {8'h00, 1'b1});
    repeat (3) @(posedge clk);
    #1;
    rstn = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    fill(40);
    check(conv_rdy, 32'h0);
    while (q.size() > 0) begin
      wait_rdy();
      rd(5, v);
      check(v, q.pop_front());
    end
    results();
  end
  // whole run needs roughly 16k cycles; 40k cycles leaves a wide margin
  initial begin
    #400000;
    num_errors++;
    results();
  end
endmodule
